// [design/vde_pkg.sv]
// constants and carrier types for the video delta encoder sequencer
// assumes a single 100 MHz clock domain and an axi4-lite register port
package vde_pkg;
  // register map, byte addresses
  localparam logic [3:0]  CTRL_ADDR      = 4'h0;
  localparam logic [3:0]  STATUS_ADDR    = 4'h4;
  localparam logic [3:0]  FILL_ADDR      = 4'h8;
  localparam int          CTRL_FILL_BIT  = 0;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  // header words
  localparam logic [29:0] TIME_WORD      = 30'h01010101;
  localparam logic [7:0]  VSYNC_CODE     = 8'hf1;  // arbitrary pattern
  localparam logic [7:0]  HSYNC_CODE     = 8'hf2;  // arbitrary pattern
  localparam logic [7:0]  SPARE_WORD     = 8'h00;
  localparam logic [1:0]  TIME_SEG_LAST  = 2'h3;
  localparam logic [3:0]  TIME_SEG_LEN   = 4'h8;
  localparam logic [3:0]  TIME_TAIL_LEN  = 4'h6;

  // quantization level codes carried in the absolute value word
  localparam logic [1:0]  QL6            = 2'h2;
  localparam logic [1:0]  QL5            = 2'h1;
  localparam logic [1:0]  QL4            = 2'h0;

  // fill counter and its two switchable thresholds
  localparam logic signed [9:0] FILL_PRESET = 10'sh080;
  localparam logic signed [9:0] THR_LO_A    = 10'sh078;
  localparam logic signed [9:0] THR_LO_B    = 10'sh07c;
  localparam logic signed [9:0] THR_HI_A    = 10'sh088;
  localparam logic signed [9:0] THR_HI_B    = 10'sh084;

  // default code set: bits left aligned, sent msb first
  localparam logic [3:0]  LEN_ZERO       = 4'h1;
  localparam logic [3:0]  LEN_ONE        = 4'h3;
  localparam logic [3:0]  LEN_TWO        = 4'h5;
  localparam logic [3:0]  LEN_THREE      = 4'h6;
  localparam logic [3:0]  LEN_REM        = 4'h8;
  localparam logic [3:0]  REM_PREFIX     = 4'hf;
  localparam logic [4:0]  WORD_BITS      = 5'h1e;

  typedef enum logic [2:0] {
    ST_VIDEO, ST_BLANK, ST_TIME, ST_SYNC, ST_SPARE, ST_ABS
  } vde_state_t;

  typedef struct packed {
    logic [7:0] bits;
    logic [3:0] len;
  } vde_code_t;
endpackage : vde_pkg

// [design/vde_sequencer.sv]
// sequencer, quantizer, code selector and 30-bit packer of a video delta encoder
// assumes all inputs except sample_strobe synchronous to aclk; the rate buffer takes buf_word on buf_load
//
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
module vde_sequencer (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        sample_strobe,
  input  wire logic        hblank,
  input  wire logic        vblank,
  input  wire logic [5:0]  video_in,
  input  wire logic        near_empty,
  input  wire logic        buf_read,
  output logic             ready_load,
  output logic             transfer,
  output logic             load_cmd,
  output logic [1:0]       quant_level_select,
  output logic [29:0]      buf_word,
  output logic             buf_load
);
  // quantize a six bit sample, filling vacated high bits with ones
  function automatic logic [5:0] quantize(input logic [5:0] v, input logic [1:0] ql);
    logic [5:0] q;
    q = v;
    if (ql == vde_pkg::QL5) begin
      q = {1'b1, v[5:1]};
    end else if (ql == vde_pkg::QL4) begin
      q = {2'b11, v[5:2]};
    end
    return q;
  endfunction : quantize
  logic                   strobe_s1_reg;
  logic                   strobe_s2_reg;
  logic                   strobe_s3_reg;
  logic                   blank_now;
  logic                   load_now;
  logic                   fill_sel_reg;
  logic                   vblank_seen_reg;
  logic [1:0]             seg_reg;
  logic [5:0]             cur_reg;
  logic [5:0]             prev_reg;
  logic [7:0]             code_sr_reg;
  logic [3:0]             bits_left_reg;
  logic [29:0]            acc_reg;
  logic [29:0]            acc_next;
  logic [4:0]             count_reg;
  logic signed [9:0]      fill_reg;
  logic signed [9:0]      fill_last_reg;
  logic signed [9:0]      thr_lo;
  logic signed [9:0]      thr_hi;
  logic signed [6:0]      delta;
  logic [1:0]             ql_eval;
  logic                   eval_now;
  vde_pkg::vde_state_t    state_reg;
  vde_pkg::vde_state_t    eff_state;
  vde_pkg::vde_state_t    state_next;
  vde_pkg::vde_code_t     code;
  logic                   aw_held_reg;
  logic                   w_held_reg;
  logic [3:0]             awaddr_reg;
  logic [31:0]            wdata_reg;
  logic [3:0]             wstrb_reg;

  assign blank_now = hblank | vblank;
  // strobe synchroniser; the edge is taken past stage two so stage one feeds only it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strobe_s1_reg <= 1'b0;
      strobe_s2_reg <= 1'b0;
      strobe_s3_reg <= 1'b0;
      ready_load    <= 1'b0;
      transfer      <= 1'b0;
    end else begin
      strobe_s1_reg <= sample_strobe;
      strobe_s2_reg <= strobe_s1_reg;
      strobe_s3_reg <= strobe_s2_reg;
      ready_load    <= strobe_s2_reg & ~strobe_s3_reg;
      transfer      <= ready_load;
    end
  end

  // loads pass except while blanking persists past its first load
  assign load_now = ready_load & ~((state_reg == vde_pkg::ST_BLANK) & blank_now);
  // a blank state leaving on this pulse already emits its first header
  always_comb begin
    eff_state = state_reg;
    if (state_reg == vde_pkg::ST_BLANK && !blank_now) begin
      eff_state = vblank_seen_reg ? vde_pkg::ST_TIME : vde_pkg::ST_SYNC;
    end
  end

  // header sequence order, advanced once per load
  always_comb begin
    state_next = eff_state;
    unique case (eff_state)
      vde_pkg::ST_VIDEO: begin
        if (blank_now) begin
          state_next = vde_pkg::ST_BLANK;
        end
      end
      vde_pkg::ST_BLANK: state_next = vde_pkg::ST_BLANK;
      vde_pkg::ST_TIME: begin
        if (seg_reg == vde_pkg::TIME_SEG_LAST) begin
          state_next = vde_pkg::ST_SYNC;
        end
      end
      vde_pkg::ST_SYNC:  state_next = vde_pkg::ST_SPARE;
      vde_pkg::ST_SPARE: state_next = vde_pkg::ST_ABS;
      vde_pkg::ST_ABS:   state_next = vde_pkg::ST_VIDEO;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= vde_pkg::ST_BLANK;
    end else if (ready_load) begin
      state_reg <= state_next;
    end
  end

  // remembers whether the current blanking interval was vertical
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vblank_seen_reg <= 1'b0;
    end else if (ready_load && state_reg == vde_pkg::ST_VIDEO && blank_now) begin
      vblank_seen_reg <= vblank;
    end else if (ready_load && state_reg == vde_pkg::ST_BLANK && vblank) begin
      vblank_seen_reg <= 1'b1;
    end
  end

  // time word segment counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seg_reg <= 2'h0;
    end else if (ready_load) begin
      seg_reg <= (eff_state == vde_pkg::ST_TIME) ? seg_reg + 2'h1 : 2'h0;
    end
  end

  // holding registers move on transfer, after the code was chosen
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_reg  <= 6'h00;
      prev_reg <= 6'h00;
    end else if (transfer) begin
      prev_reg <= cur_reg;
      cur_reg  <= quantize(video_in, quant_level_select);
    end
  end

  assign delta = 7'(signed'({1'b0, cur_reg})) - 7'(signed'({1'b0, prev_reg}));
  // code selector; near empty overrides every delta code
  always_comb begin
    code = '{bits: 8'h00, len: vde_pkg::LEN_ZERO};
    unique case (eff_state)
      vde_pkg::ST_TIME: begin
        if (seg_reg == vde_pkg::TIME_SEG_LAST) begin
          code = '{bits: {vde_pkg::TIME_WORD[5:0], 2'b00}, len: vde_pkg::TIME_TAIL_LEN};
        end else begin
          code = '{bits: 8'(vde_pkg::TIME_WORD >> (5'h16 - 5'(seg_reg) * 5'h08)),
                   len: vde_pkg::TIME_SEG_LEN};
        end
      end
      vde_pkg::ST_SYNC: begin
        code = '{bits: vblank_seen_reg ? vde_pkg::VSYNC_CODE : vde_pkg::HSYNC_CODE,
                 len: vde_pkg::LEN_REM};
      end
      vde_pkg::ST_SPARE: code = '{bits: vde_pkg::SPARE_WORD, len: vde_pkg::LEN_REM};
      vde_pkg::ST_ABS: begin
        code = '{bits: {quant_level_select, cur_reg}, len: vde_pkg::LEN_REM};
      end
      vde_pkg::ST_BLANK, vde_pkg::ST_VIDEO: begin
        if (near_empty || delta > 7'sd3 || delta < -7'sd3) begin
          code = '{bits: {vde_pkg::REM_PREFIX, cur_reg[5:2]}, len: vde_pkg::LEN_REM};
        end else if (delta == 7'sd0) begin
          code = '{bits: 8'h00, len: vde_pkg::LEN_ZERO};
        end else if (delta == 7'sd1 || delta == -7'sd1) begin
          code = '{bits: {2'b10, delta[6], 5'h00}, len: vde_pkg::LEN_ONE};
        end else if (delta == 7'sd2 || delta == -7'sd2) begin
          code = '{bits: {4'b1100, delta[6], 3'h0}, len: vde_pkg::LEN_TWO};
        end else begin
          code = '{bits: {5'b11010, delta[6], 2'h0}, len: vde_pkg::LEN_THREE};
        end
      end
    endcase
  end

  // load command and code register; an eight-bit burst ends well before the next sample
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      load_cmd      <= 1'b0;
      code_sr_reg   <= 8'h00;
      bits_left_reg <= 4'h0;
    end else begin
      load_cmd <= load_now;
      if (load_now) begin
        code_sr_reg   <= code.bits;
        bits_left_reg <= code.len;
      end else if (bits_left_reg != 4'h0) begin
        code_sr_reg   <= {code_sr_reg[6:0], 1'b0};
        bits_left_reg <= bits_left_reg - 4'h1;
      end
    end
  end

  // output packer, one code bit per clock of the burst
  assign acc_next = {acc_reg[28:0], code_sr_reg[7]};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_reg   <= 30'h0;
      count_reg <= 5'h00;
      buf_word  <= 30'h0;
      buf_load  <= 1'b0;
    end else begin
      buf_load <= 1'b0;
      if (bits_left_reg != 4'h0 && !load_now) begin
        if (count_reg == vde_pkg::WORD_BITS - 5'h01) begin
          buf_word  <= acc_next;
          buf_load  <= 1'b1;
          acc_reg   <= 30'h0;
          count_reg <= 5'h00;
        end else begin
          acc_reg   <= acc_next;
          count_reg <= count_reg + 5'h01;
        end
      end
    end
  end

  // end of a line is the load that enters blanking
  assign eval_now = ready_load & (state_reg == vde_pkg::ST_VIDEO) & blank_now;
  assign thr_lo   = fill_sel_reg ? vde_pkg::THR_LO_B : vde_pkg::THR_LO_A;
  assign thr_hi   = fill_sel_reg ? vde_pkg::THR_HI_B : vde_pkg::THR_HI_A;
  always_comb begin
    if (fill_reg < thr_lo) begin
      ql_eval = vde_pkg::QL6;
    end else if (fill_reg < thr_hi) begin
      ql_eval = vde_pkg::QL5;
    end else begin
      ql_eval = vde_pkg::QL4;
    end
  end

  // fill counter; the reload absorbs same-cycle words, else they would be lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fill_reg           <= vde_pkg::FILL_PRESET;
      fill_last_reg      <= vde_pkg::FILL_PRESET;
      quant_level_select <= vde_pkg::QL6;
    end else if (eval_now) begin
      fill_last_reg      <= fill_reg;
      quant_level_select <= ql_eval;
      fill_reg           <= vde_pkg::FILL_PRESET + 10'(buf_load) - 10'(buf_read);
    end else begin
      fill_reg <= fill_reg + 10'(buf_load) - 10'(buf_read);
    end
  end
  // axi write: address and data taken in either order, answer after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      awaddr_reg    <= 4'h0;
      wdata_reg     <= 32'h0;
      wstrb_reg     <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= vde_pkg::RESP_OKAY;
      fill_sel_reg  <= 1'b0;
    end else begin
      s_axi_awready <= ~aw_held_reg & ~s_axi_awready & s_axi_awvalid & ~s_axi_bvalid;
      s_axi_wready  <= ~w_held_reg & ~s_axi_wready & s_axi_wvalid & ~s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (aw_held_reg && w_held_reg && !s_axi_bvalid) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= vde_pkg::RESP_OKAY;
        if (awaddr_reg == vde_pkg::CTRL_ADDR) begin
          if (wstrb_reg[0]) begin
            fill_sel_reg <= wdata_reg[vde_pkg::CTRL_FILL_BIT];
          end
        end else if (awaddr_reg != vde_pkg::STATUS_ADDR && awaddr_reg != vde_pkg::FILL_ADDR) begin
          s_axi_bresp <= vde_pkg::RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // axi read, one outstanding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= vde_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & s_axi_arvalid & ~s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= vde_pkg::RESP_OKAY;
        unique case (s_axi_araddr)
          vde_pkg::CTRL_ADDR:   s_axi_rdata <= {31'h0, fill_sel_reg};
          vde_pkg::STATUS_ADDR: s_axi_rdata <= {24'h0, near_empty, vblank_seen_reg,
                                                3'(state_reg), 1'b0, quant_level_select};
          vde_pkg::FILL_ADDR:   s_axi_rdata <= {22'h0, fill_last_reg};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= vde_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : vde_sequencer

// [verification/vde_sequencer_props.sv]
// assertion checker on the top ports of the video delta encoder sequencer
// assumes one aclk domain with synchronous active-low aresetn
`timescale 1ns/100ps
module vde_sequencer_props (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       sample_strobe,
  input wire logic       hblank,
  input wire logic       vblank,
  input wire logic       ready_load,
  input wire logic       transfer,
  input wire logic       load_cmd,
  input wire logic [1:0] quant_level_select,
  input wire logic       buf_load,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready
);
  logic [1:0] blank_loads_reg;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // loads seen inside one blanking span; saturates so it cannot wrap back to legal
  always_ff @(posedge aclk) begin
    if (!aresetn || !(hblank || vblank)) blank_loads_reg <= 2'h0;
    else if (load_cmd && blank_loads_reg != 2'h3) blank_loads_reg <= blank_loads_reg + 2'h1;
  end

  AST_RDY_AFTER_STROBE: assert property ($rose(sample_strobe) |-> ##3 ready_load)
    else $error("ready_load late after strobe rise");
  AST_XFER_FOLLOWS: assert property (ready_load |=> transfer)
    else $error("transfer missing after ready_load");
  AST_XFER_CAUSE: assert property (transfer |-> $past(ready_load))
    else $error("transfer without ready_load");
  AST_LOAD_WITH_XFER: assert property (load_cmd |-> transfer)
    else $error("load_cmd outside transfer cycle");
  AST_LOAD_IN_LINE: assert property (ready_load && !hblank && !vblank |=> load_cmd)
    else $error("load_cmd missing in active line");
  AST_BLANK_ONE_LOAD: assert property (blank_loads_reg <= 2'h1)
    else $error("more than one load in blanking");
  AST_QL_AT_LINE_END: assert property ($changed(quant_level_select) |-> hblank || vblank)
    else $error("quant level changed mid line");
  AST_BUF_SPACING: assert property (buf_load |=> !buf_load [*8])
    else $error("packed words too close");
  AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped before bready");
endmodule : vde_sequencer_props

bind vde_sequencer vde_sequencer_props vde_sequencer_props_inst (
  .aclk, .aresetn, .sample_strobe, .hblank, .vblank, .ready_load, .transfer, .load_cmd,
  .quant_level_select, .buf_load, .s_axi_bvalid, .s_axi_bready
);

// [verification/vde_rate_buffer_model.sv]
// rate buffer model: stores packed words, flags near empty at four words or fewer
// assumes the encoder's aclk; ne_en lets the bench switch the flag on, rd_req asks for reads
`timescale 1ns/100ps
module vde_rate_buffer_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [29:0] buf_word,
  input  wire logic        buf_load,
  input  wire logic        ne_en,
  input  wire logic        rd_req,
  output logic             near_empty,
  output logic             buf_read
);
  logic [29:0] mem_reg [512];
  logic [9:0]  cnt_reg;

  // words kept as a stack; the count floors at zero, deeper reads stand for older lines
  always_ff @(posedge aclk) begin
    if (!aresetn) cnt_reg <= 10'h0;
    else begin
      if (buf_load) mem_reg[cnt_reg[8:0]] <= buf_word;
      if (buf_load && !buf_read) cnt_reg <= cnt_reg + 10'h1;
      else if (buf_read && !buf_load && cnt_reg != 10'h0) cnt_reg <= cnt_reg - 10'h1;
    end
  end

  // flag and read strobe; reads follow the bench's demand
  assign near_empty = ne_en && (cnt_reg <= 10'h4);
  assign buf_read   = rd_req;
endmodule : vde_rate_buffer_model

// [verification/vde_sequencer_tb_top.sv]
// self-checking bench for the video delta encoder sequencer
// assumes vde_pkg, the design, its checker and the rate buffer model compiled first
`timescale 1ns/100ps
module vde_sequencer_tb_top;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp, quant_level_select;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        sample_strobe = 1'b0, hblank = 1'b0, vblank = 1'b1, ne_en = 1'b0, rd_req = 1'b0;
  logic [5:0]  video_in = 6'h15;
  logic        near_empty, buf_read, ready_load, transfer, load_cmd, buf_load;
  logic [29:0] buf_word;
  logic [29:0] got[$];
  int          n_fail = 0, cmp_count = 0, n_load = 0;

  vde_sequencer vde_sequencer_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .sample_strobe, .hblank, .vblank, .video_in, .near_empty, .buf_read,
    .ready_load, .transfer, .load_cmd, .quant_level_select, .buf_word, .buf_load
  );
  vde_rate_buffer_model vde_rate_buffer_model_inst (
    .aclk, .aresetn, .buf_word, .buf_load, .ne_en, .rd_req, .near_empty, .buf_read
  );

  always #5 aclk = ~aclk;

  // record packed words and count load commands
  always @(posedge aclk) begin
    if (buf_load) got.push_back(buf_word);
    if (load_cmd) n_load++;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // write: address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  // strobes spaced 14 cycles, above the minimum spacing of the sample path
  task automatic strobe(input int n);
    repeat (n) begin
      sample_strobe <= 1'b1;
      repeat (2) @(posedge aclk);
      sample_strobe <= 1'b0;
      repeat (12) @(posedge aclk);
    end
  endtask : strobe

  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(vde_pkg::STATUS_ADDR, d, r);
    chk("status_level", {30'h0, vde_pkg::QL6}, {30'h0, d[1:0]});
    chk("status_state", 32'h1, {29'h0, d[5:3]});
    axi_wr(vde_pkg::CTRL_ADDR, 32'h1, r);
    chk("ctrl_wr_resp", {30'h0, vde_pkg::RESP_OKAY}, {30'h0, r});
    axi_rd(vde_pkg::CTRL_ADDR, d, r);
    chk("ctrl_select", 32'h1, d);
    chk("ctrl_rd_resp", {30'h0, vde_pkg::RESP_OKAY}, {30'h0, r});
    axi_rd(4'hc, d, r);
    chk("unmapped_resp", {30'h0, vde_pkg::RESP_SLVERR}, {30'h0, r});
  endtask : t_regs

  // vertical blanking, then time word, sync set and 36 zero deltas: three words
  task automatic t_vline();
    strobe(3);
    chk("vblank_loads", 32'h0, n_load);
    vblank <= 1'b0;
    strobe(43);
    chk("line1_words", 32'h3, got.size());
    chk("time_word", {2'h0, 30'b000001000000010000000100000001}, {2'h0, got[0]});
    chk("vsync_set", {2'h0, vde_pkg::VSYNC_CODE, vde_pkg::SPARE_WORD, vde_pkg::QL6, 6'h15,
        6'h0}, {2'h0, got[1]});
    chk("zero_codes", 32'h0, {2'h0, got[2]});
  endtask : t_vline

  // line end with three words counted (fill count 131), then horizontal header and forced remainders
  task automatic t_hline();
    logic [31:0] d;
    logic [1:0]  r;
    int          n0;
    n0 = n_load;
    hblank <= 1'b1;
    strobe(3);
    chk("hblank_loads", 32'h1, n_load - n0);
    chk("next_level", {30'h0, vde_pkg::QL5}, {30'h0, quant_level_select});
    axi_rd(vde_pkg::FILL_ADDR, d, r);
    chk("fill_count", 32'(vde_pkg::FILL_PRESET) + 32'h3, {{22{d[9]}}, d[9:0]});
    ne_en <= 1'b1;
    hblank <= 1'b0;
    strobe(8);
    chk("line2_words", 32'h5, got.size());
    chk("hsync_set", {3'h0, vde_pkg::HSYNC_CODE, vde_pkg::SPARE_WORD, vde_pkg::QL5, 6'h2a,
        5'h1f}, {2'h0, got[3]});
    chk("remainders", {2'h0, 3'h2, 24'hfafafa, 3'h7}, {2'h0, got[4]});
  endtask : t_hline

  // eight reads drop the count to 122, below the selected low threshold of 124
  task automatic t_drain();
    logic [31:0] d;
    logic [1:0]  r;
    ne_en <= 1'b0;
    rd_req <= 1'b1;
    repeat (8) @(posedge aclk);
    rd_req <= 1'b0;
    hblank <= 1'b1;
    strobe(1);
    chk("drain_level", {30'h0, vde_pkg::QL6}, {30'h0, quant_level_select});
    axi_rd(vde_pkg::FILL_ADDR, d, r);
    chk("drain_fill", 32'(vde_pkg::FILL_PRESET) + 32'h2 - 32'h8, {{22{d[9]}}, d[9:0]});
    chk("fill_rd_resp", {30'h0, vde_pkg::RESP_OKAY}, {30'h0, r});
  endtask : t_drain

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  // main sequence after 16 cycles of reset
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_vline();
    t_hline();
    t_drain();
    summarize();
  end

  // watchdog: the run needs about 860 cycles
  initial begin
    #50000;
    n_fail++;
    summarize();
  end
endmodule : vde_sequencer_tb_top
